/* verilog/dfrt_map.svh */
// Purpose: Register offsets, field positions, reset values and timing counts of the timer pair.
// Assumes: 32-bit register words on byte addresses.
// Notes:   Definitions only.
`ifndef DFRT_MAP_SVH
`define DFRT_MAP_SVH

`define DFRT_OFF_DN_LOAD     8'h00
`define DFRT_OFF_DN_COUNT    8'h04
`define DFRT_OFF_DN_CTRL     8'h08
`define DFRT_OFF_DN_INT      8'h0c
`define DFRT_OFF_UP_LOAD     8'h20
`define DFRT_OFF_UP_COUNT    8'h24
`define DFRT_OFF_UP_CTRL     8'h28
`define DFRT_OFF_UP_INT      8'h2c
`define DFRT_OFF_UP_ALARM    8'h30
`define DFRT_OFF_IRQ_STAT    8'h40
`define DFRT_OFF_IRQ_CLR     8'h44
`define DFRT_OFF_IRQ_EN      8'h48

`define DFRT_CTRL_ENABLE     7
`define DFRT_CTRL_RELOAD     6
`define DFRT_CTRL_PRE_HI     3
`define DFRT_CTRL_PRE_LO     2
`define DFRT_CTRL_LEVEL      0
`define DFRT_CTRL_STATUS     8
`define DFRT_INT_CLEAR       0

`define DFRT_DN_COUNT_RST    23'h7f_ffff
`define DFRT_UP_COUNT_RST    32'h0000_0001
`define DFRT_PRE_DIV16_LAST  4'hf
`define DFRT_PRE_DIV256_LAST 8'hff

`endif

/* verilog/dfrt_pkg.sv */
// Purpose: Types shared by the timer pair.
// Assumes: Nothing beyond the map header.
// Notes:   Bus requests travel as one packed struct.
`default_nettype none
package dfrt_pkg;
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} dfrt_req_t;

	typedef enum logic [1:0] {
		DFRT_PRE_1   = 2'h0,
		DFRT_PRE_16  = 2'h1,
		DFRT_PRE_256 = 2'h3
	} dfrt_pre_t;
endpackage
`default_nettype wire

/* verilog/dfrt_timer.sv */
// Purpose: Two programmable timers, a 23-bit down counter and a 32-bit up counter with alarm.
// Assumes: One 100 MHz clock, synchronous active-high reset, single-cycle register port.
// Notes:   Timer irq outputs pulse in edge mode and hold in level mode until cleared.
// Operation
// - Load registers, 23 and 32 bits, reset zero.
// - Down count decrements per tick when enabled.
// - Counts reset to all ones and one.
// - Up count increments per tick when enabled.
// - Down status sets when count reaches zero.
// - Up status sets on alarm match.
// - Alarm register, 32 bits, reset zero.
// - Control bit 6 reloads count at zero.
// - Prescaler divides by 1, 16, 256.
// - Control bit 0 picks edge or level.
// - Level mode status cleared by write bit0.
//
// Strobed register access is this design's own decision.
`include "dfrt_map.svh"
`default_nettype none
module dfrt_timer
(
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        srst_in,
	// Register port
	input  wire logic [7:0]  addr_in,
	input  wire logic [31:0] wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	output logic      [31:0] rdata_out,
	// Interrupts
	output logic             down_irq_out,
	output logic             up_irq_out,
	output logic             irq_out
);
	dfrt_pkg::dfrt_req_t req;
	assign req = '{wr: wr_in, rd: rd_in, addr: addr_in, wdata: wdata_in};

	function automatic logic hit(input dfrt_pkg::dfrt_req_t r, input logic [7:0] off);
		hit = r.wr && (r.addr == off);
	endfunction

	function automatic logic pre_tick(input logic [1:0] sel, input logic [7:0] cnt);
		case (sel)
			dfrt_pkg::DFRT_PRE_1:  pre_tick = 1'b1;
			dfrt_pkg::DFRT_PRE_16: pre_tick = (cnt[3:0] == `DFRT_PRE_DIV16_LAST);
			default: pre_tick = (cnt == `DFRT_PRE_DIV256_LAST);
		endcase
	endfunction

	logic [22:0] down_load_value_q;
	logic [22:0] down_count_value_q;
	logic [7:0]  down_control_field_q;
	logic        down_irq_status_q;
	logic [31:0] up_load_value_q;
	logic [31:0] up_count_value_q;
	logic [7:0]  up_control_field_q;
	logic        up_irq_status_q;
	logic [31:0] up_alarm_value_q;
	logic [7:0]  down_pre_q;
	logic [7:0]  up_pre_q;
	logic [1:0]  irq_en_q;
	logic [1:0]  irq_stat_q;
	logic        down_tick;
	logic        up_tick;
	logic        down_event;
	logic        up_event;
	logic [31:0] up_next;
	logic        down_clr;
	logic        up_clr;

	// Load, alarm and control registers.
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			down_load_value_q    <= 23'h00_0000;
			up_load_value_q      <= 32'h0000_0000;
			up_alarm_value_q     <= 32'h0000_0000;
			down_control_field_q <= 8'h00;
			up_control_field_q   <= 8'h00;
			irq_en_q             <= 2'h0;
		end
		else
		begin
			if (hit(req, `DFRT_OFF_DN_LOAD))
				down_load_value_q <= req.wdata[22:0];
			if (hit(req, `DFRT_OFF_UP_LOAD))
				up_load_value_q <= req.wdata;
			if (hit(req, `DFRT_OFF_UP_ALARM))
				up_alarm_value_q <= req.wdata;
			if (hit(req, `DFRT_OFF_DN_CTRL))
				down_control_field_q <= req.wdata[7:0];
			if (hit(req, `DFRT_OFF_UP_CTRL))
				up_control_field_q <= req.wdata[7:0];
			if (hit(req, `DFRT_OFF_IRQ_EN))
				irq_en_q <= req.wdata[1:0];
		end
	end

	// Prescalers run only while their timer is enabled so the first tick is a full period.
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			down_pre_q <= 8'h00;
			up_pre_q   <= 8'h00;
		end
		else
		begin
			down_pre_q <= down_control_field_q[`DFRT_CTRL_ENABLE] ? down_pre_q + 8'h01 : 8'h00;
			up_pre_q   <= up_control_field_q[`DFRT_CTRL_ENABLE] ? up_pre_q + 8'h01 : 8'h00;
		end
	end

	assign down_tick = down_control_field_q[`DFRT_CTRL_ENABLE]
		&& pre_tick(down_control_field_q[3:2], down_pre_q);
	assign up_tick = up_control_field_q[`DFRT_CTRL_ENABLE]
		&& pre_tick(up_control_field_q[3:2], up_pre_q);

	// Down timer: a tick at count one lands on zero, which is the terminal event.
	assign down_event = down_tick && (down_count_value_q == 23'h00_0001);
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
			down_count_value_q <= `DFRT_DN_COUNT_RST;
		else if (down_tick)
		begin
			if (down_count_value_q == 23'h00_0000 && down_control_field_q[`DFRT_CTRL_RELOAD])
				down_count_value_q <= down_load_value_q;
			else if (down_count_value_q != 23'h00_0000)
				down_count_value_q <= down_count_value_q - 23'h00_0001;
		end
		else if (hit(req, `DFRT_OFF_DN_LOAD))
			down_count_value_q <= req.wdata[22:0];
	end

	// Up timer: wraps freely; reload at zero applies when it rolls over.
	// The alarm compares the value that the tick is about to store, so a reload that lands
	// on the alarm value raises the event as well.
	assign up_next = (up_count_value_q == 32'h0000_0000 && up_control_field_q[`DFRT_CTRL_RELOAD])
		? up_load_value_q : up_count_value_q + 32'h0000_0001;
	assign up_event = up_tick && (up_next == up_alarm_value_q);
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
			up_count_value_q <= `DFRT_UP_COUNT_RST;
		else if (up_tick)
		begin
			if (up_count_value_q == 32'h0000_0000 && up_control_field_q[`DFRT_CTRL_RELOAD])
				up_count_value_q <= up_load_value_q;
			else
				up_count_value_q <= up_count_value_q + 32'h0000_0001;
		end
		else if (hit(req, `DFRT_OFF_UP_LOAD))
			up_count_value_q <= req.wdata;
	end

	assign down_clr = hit(req, `DFRT_OFF_DN_INT) && req.wdata[`DFRT_INT_CLEAR];
	assign up_clr   = hit(req, `DFRT_OFF_UP_INT) && req.wdata[`DFRT_INT_CLEAR];

	// Status bits; a new event wins over a clear in the same cycle.
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			down_irq_status_q <= 1'b0;
			up_irq_status_q   <= 1'b0;
		end
		else
		begin
			if (down_event)
				down_irq_status_q <= 1'b1;
			else if (down_clr && down_control_field_q[`DFRT_CTRL_LEVEL])
				down_irq_status_q <= 1'b0;
			else if (!down_control_field_q[`DFRT_CTRL_LEVEL])
				down_irq_status_q <= 1'b0;
			if (up_event)
				up_irq_status_q <= 1'b1;
			else if (up_clr && up_control_field_q[`DFRT_CTRL_LEVEL])
				up_irq_status_q <= 1'b0;
			else if (!up_control_field_q[`DFRT_CTRL_LEVEL])
				up_irq_status_q <= 1'b0;
		end
	end

	// Irq lines mirror status: one cycle in edge mode, held in level mode.
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			down_irq_out <= 1'b0;
			up_irq_out   <= 1'b0;
		end
		else
		begin
			down_irq_out <= down_event || down_irq_status_q &&
				down_control_field_q[`DFRT_CTRL_LEVEL] && !down_clr;
			up_irq_out   <= up_event || up_irq_status_q &&
				up_control_field_q[`DFRT_CTRL_LEVEL] && !up_clr;
		end
	end

	// Sticky summary status with enable and write-one-to-clear.
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			irq_stat_q <= 2'h0;
			irq_out    <= 1'b0;
		end
		else
		begin
			for (int i = 0; i < 2; i++)
			begin
				if ((i == 0) ? down_event : up_event)
					irq_stat_q[i] <= 1'b1;
				else if (hit(req, `DFRT_OFF_IRQ_CLR) && req.wdata[i])
					irq_stat_q[i] <= 1'b0;
			end
			irq_out <= |(irq_stat_q & irq_en_q);
		end
	end

	// Read data stand one cycle after the strobe; unmapped addresses read zero.
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
			rdata_out <= 32'h0000_0000;
		else if (!req.rd)
			rdata_out <= 32'h0000_0000;
		else
		begin
			case (req.addr)
				`DFRT_OFF_DN_LOAD:  rdata_out <= {9'h000, down_load_value_q};
				`DFRT_OFF_DN_COUNT: rdata_out <= {9'h000, down_count_value_q};
				`DFRT_OFF_DN_CTRL:
					rdata_out <= {23'h00_0000, down_irq_status_q, down_control_field_q};
				`DFRT_OFF_UP_LOAD:  rdata_out <= up_load_value_q;
				`DFRT_OFF_UP_COUNT: rdata_out <= up_count_value_q;
				`DFRT_OFF_UP_CTRL:
					rdata_out <= {23'h00_0000, up_irq_status_q, up_control_field_q};
				`DFRT_OFF_UP_ALARM: rdata_out <= up_alarm_value_q;
				`DFRT_OFF_IRQ_STAT: rdata_out <= {30'h0000_0000, irq_stat_q};
				`DFRT_OFF_IRQ_EN:   rdata_out <= {30'h0000_0000, irq_en_q};
				default:            rdata_out <= 32'h0000_0000;
			endcase
		end
	end

	// Checks.
	property p_dn_reset_count;
		@(posedge clk_in) srst_in |=> (down_count_value_q == `DFRT_DN_COUNT_RST);
	endproperty
	a_dn_reset_count: assert property (p_dn_reset_count) else $error("down count reset wrong");

	property p_up_reset_count;
		@(posedge clk_in) srst_in |=> (up_count_value_q == `DFRT_UP_COUNT_RST);
	endproperty
	a_up_reset_count: assert property (p_up_reset_count) else $error("up count reset wrong");

	property p_dn_dec;
		@(posedge clk_in) disable iff (srst_in)
		down_tick && down_count_value_q > 23'h00_0000 |=>
			down_count_value_q == $past(down_count_value_q) - 23'h00_0001;
	endproperty
	a_dn_dec: assert property (p_dn_dec) else $error("down count did not decrement");

	property p_up_inc;
		@(posedge clk_in) disable iff (srst_in)
		up_tick && up_count_value_q != 32'h0000_0000 |=>
			up_count_value_q == $past(up_count_value_q) + 32'h0000_0001;
	endproperty
	a_up_inc: assert property (p_up_inc) else $error("up count did not increment");

	property p_dn_zero_status;
		@(posedge clk_in) disable iff (srst_in)
		down_event |=> down_irq_status_q && down_count_value_q == 23'h00_0000;
	endproperty
	a_dn_zero_status: assert property (p_dn_zero_status) else $error("zero status missing");

	property p_up_alarm;
		@(posedge clk_in) disable iff (srst_in)
		up_event |=> up_irq_status_q && up_count_value_q == $past(up_alarm_value_q);
	endproperty
	a_up_alarm: assert property (p_up_alarm) else $error("alarm status missing");

	property p_dn_reload;
		@(posedge clk_in) disable iff (srst_in)
		down_tick && down_count_value_q == 23'h00_0000 && down_control_field_q[6] |=>
			down_count_value_q == $past(down_load_value_q);
	endproperty
	a_dn_reload: assert property (p_dn_reload) else $error("reload missed");

	property p_div16;
		@(posedge clk_in) disable iff (srst_in)
		down_tick && down_control_field_q == 8'h84 ##1 down_control_field_q == 8'h84 [*8]
			|-> !down_tick;
	endproperty
	a_div16: assert property (p_div16) else $error("prescale 16 ticked early");

	property p_edge_pulse;
		@(posedge clk_in) disable iff (srst_in)
		down_irq_out && !down_control_field_q[0] && !$past(down_control_field_q[0])
			|=> !down_irq_out;
	endproperty
	a_edge_pulse: assert property (p_edge_pulse) else $error("edge irq too long");

	property p_level_clear;
		@(posedge clk_in) disable iff (srst_in)
		down_clr && down_control_field_q[0] && !down_event |=> !down_irq_status_q;
	endproperty
	a_level_clear: assert property (p_level_clear) else $error("level clear failed");

	property p_level_hold;
		@(posedge clk_in) disable iff (srst_in)
		down_irq_status_q && down_control_field_q[`DFRT_CTRL_LEVEL] && !down_clr |=> down_irq_status_q;
	endproperty
	a_level_hold: assert property (p_level_hold) else $error("level status dropped");

	property p_up_reload;
		@(posedge clk_in) disable iff (srst_in)
		up_tick && up_count_value_q == 32'h0000_0000 && up_control_field_q[`DFRT_CTRL_RELOAD]
			|=> up_count_value_q == $past(up_load_value_q);
	endproperty
	a_up_reload: assert property (p_up_reload) else $error("up reload missed");

	property p_dn_stop;
		@(posedge clk_in) disable iff (srst_in)
		down_tick && down_count_value_q == 23'h00_0000 && !down_control_field_q[`DFRT_CTRL_RELOAD]
			|=> down_count_value_q == 23'h00_0000;
	endproperty
	a_dn_stop: assert property (p_dn_stop) else $error("down count left zero");

	property p_ctrl_upper;
		@(posedge clk_in) disable iff (srst_in)
		rd_in && (addr_in == `DFRT_OFF_DN_CTRL || addr_in == `DFRT_OFF_UP_CTRL)
			|=> rdata_out[31:9] == 23'h00_0000;
	endproperty
	a_ctrl_upper: assert property (p_ctrl_upper) else $error("control upper bits set");

	c_dn_event: cover property (@(posedge clk_in) disable iff (srst_in) down_event);
	c_up_event: cover property (@(posedge clk_in) disable iff (srst_in) up_event);
	c_level_clr: cover property (@(posedge clk_in) disable iff (srst_in)
		down_clr && down_irq_status_q);
	c_up_reload: cover property (@(posedge clk_in) disable iff (srst_in)
		up_tick && up_count_value_q == 32'h0000_0000 && up_control_field_q[`DFRT_CTRL_RELOAD]);
endmodule
`default_nettype wire

/* verif/tb_top.sv */
// Purpose: Self-checking bench for the timer pair.
// Assumes: Read data stand in the cycle after the read strobe only.
// Notes:   Rates are judged by count differences, so the tick phase does not matter.
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// Design ports
	logic        clk_in;
	logic        srst_in;
	logic [7:0]  addr_in;
	logic [31:0] wdata_in;
	logic        wr_in;
	logic        rd_in;
	logic [31:0] rdata_out;
	logic        down_irq_out;
	logic        up_irq_out;
	logic        irq_out;
	// Bench state
	int          n_errors;
	int          n_checks;
	int          k;
	int          div;
	int          npulse;
	logic        pv;
	logic [31:0] v0;
	logic [31:0] v1;
	logic [31:0] rv;

	dfrt_timer dut_u
	(
		.clk_in       (clk_in),
		.srst_in      (srst_in),
		.addr_in      (addr_in),
		.wdata_in     (wdata_in),
		.wr_in        (wr_in),
		.rd_in        (rd_in),
		.rdata_out    (rdata_out),
		.down_irq_out (down_irq_out),
		.up_irq_out   (up_irq_out),
		.irq_out      (irq_out)
	);

	initial
	begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	task automatic complete_run();
		if (n_errors == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Control word as read back: status at bit 8 over the eight control bits, the rest zero.
	function automatic logic [31:0] ctrl_word(input logic st, input logic [31:0] w);
		ctrl_word = {23'h00_0000, st, w[7:0]};
	endfunction

	// Every access ends with an idle cycle so no strobe is assigned twice in one step.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wr_in <= 1'b1;
		addr_in <= a;
		wdata_in <= d;
		@(posedge clk_in);
		wr_in <= 1'b0;
		@(posedge clk_in);
	endtask

	task automatic rdv(input logic [7:0] a, output logic [31:0] d);
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1;
		d = rdata_out;
		@(posedge clk_in);
	endtask

	task automatic chkrd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rdv(a, d);
		chk(d, exp);
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk_in);
	endtask

	// A hung run is cut short here and counted as a mismatch.
	initial
	begin
		repeat (20000) @(posedge clk_in);
		n_errors++;
		complete_run();
	end

	initial
	begin
		n_errors = 0;
		n_checks = 0;
		srst_in = 1'b1;
		wr_in = 1'b0;
		rd_in = 1'b0;
		addr_in = 8'h00;
		wdata_in = 32'h0000_0000;
		k = $urandom(61);
		idle(10);
		srst_in <= 1'b0;
		@(negedge clk_in);
		chk({29'h0, down_irq_out, up_irq_out, irq_out}, 32'h0000_0000);
		@(posedge clk_in);
		chkrd(8'h00, 32'h0000_0000);
		chkrd(8'h04, 32'h007f_ffff);
		chkrd(8'h08, 32'h0000_0000);
		chkrd(8'h20, 32'h0000_0000);
		chkrd(8'h24, 32'h0000_0001);
		chkrd(8'h30, 32'h0000_0000);
		chkrd(8'h10, 32'h0000_0000);
		v0 = $urandom();
		wr(8'h00, v0);
		chkrd(8'h00, {9'h000, v0[22:0]});
		v1 = $urandom();
		wr(8'h20, v1);
		chkrd(8'h20, v1);
		wr(8'h30, v1);
		chkrd(8'h30, v1);
		wr(8'h00, 32'h007f_ffff);
		// Each prescale code, both timers, over a random whole number of tick periods.
		for (int p = 0; p < 4; p++)
		begin
			div = (p == 0) ? 1 : (p == 1) ? 16 : 256;
			k = $urandom_range(6, 4);
			wr(8'h08, 32'h0000_0080 | 32'(p << 2));
			wr(8'h28, 32'h0000_0080 | 32'(p << 2));
			rdv(8'h04, v0);
			rdv(8'h24, rv);
			idle(k * div - 4);
			rdv(8'h04, v1);
			chk(v0 - v1, 32'(k));
			rdv(8'h24, v1);
			chk(v1 - rv, 32'(k));
		end
		wr(8'h28, 32'h0000_0000);
		wr(8'h08, 32'h0000_0000);
		wr(8'h48, 32'h0000_0003);
		wr(8'h00, 32'h0000_0005);
		chkrd(8'h04, 32'h0000_0005);
		wr(8'h08, 32'h0000_0081);
		idle(20);
		chkrd(8'h04, 32'h0000_0000);
		chkrd(8'h08, ctrl_word(1'b1, 32'h0000_0081));
		@(negedge clk_in);
		chk({30'h0, down_irq_out, irq_out}, 32'h0000_0003);
		@(posedge clk_in);
		wr(8'h0c, 32'h0000_0001);
		wr(8'h44, 32'h0000_0003);
		idle(2);
		@(negedge clk_in);
		chk({30'h0, down_irq_out, irq_out}, 32'h0000_0000);
		@(posedge clk_in);
		chkrd(8'h08, 32'h0000_0081);
		// Edge mode with reload: short pulses, repeating.
		wr(8'h08, 32'h0000_0000);
		wr(8'h00, 32'h0000_0003);
		wr(8'h08, 32'h0000_00c0);
		npulse = 0;
		pv = 1'b0;
		for (int i = 0; i < 40; i++)
		begin
			@(negedge clk_in);
			chk({31'h0, down_irq_out & pv}, 32'h0000_0000);
			if (down_irq_out === 1'b1)
				npulse++;
			pv = down_irq_out;
		end
		@(posedge clk_in);
		// Load 3 with reload gives one pulse every four cycles: ten in forty samples.
		chk(32'(npulse), 32'h0000_000a);
		wr(8'h08, 32'h0000_0000);
		wr(8'h44, 32'h0000_0003);
		wr(8'h20, 32'h0000_0000);
		wr(8'h30, 32'h0000_0028);
		wr(8'h28, 32'h0000_0081);
		idle(60);
		@(negedge clk_in);
		chk({30'h0, up_irq_out, irq_out}, 32'h0000_0003);
		@(posedge clk_in);
		chkrd(8'h28, ctrl_word(1'b1, 32'h0000_0081));
		chkrd(8'h40, 32'h0000_0002);
		wr(8'h48, 32'h0000_0000);
		idle(2);
		@(negedge clk_in);
		chk({31'h0, irq_out}, 32'h0000_0000);
		@(posedge clk_in);
		wr(8'h2c, 32'h0000_0001);
		idle(2);
		@(negedge clk_in);
		chk({31'h0, up_irq_out}, 32'h0000_0000);
		@(posedge clk_in);
		// Up reload after the wrap: two below the top gives a cycle of four counts.
		wr(8'h28, 32'h0000_0000);
		wr(8'h20, 32'hffff_fffd);
		wr(8'h28, 32'h0000_00c0);
		rdv(8'h24, v0);
		rdv(8'h24, rv);
		rdv(8'h24, v1);
		chk(32'(rv != v0), 32'h0000_0001);
		chk(v1, v0);
		wr(8'h28, 32'h0000_0000);
		wr(8'h08, 32'hffff_ff7f);
		chkrd(8'h08, ctrl_word(1'b0, 32'hffff_ff7f));
		wr(8'h0c, 32'hffff_fffe);
		chkrd(8'h0c, 32'h0000_0000);
		complete_run();
	end
endmodule
`default_nettype wire
